// File: dv/testbench.sv
/*
 Self-checking bench for the gripper sequencer, both output variants.
 Assumes the controller model above and a 1 ms tick of 10 cycles.
*/
`timescale 1ns/100ps
module testbench;
    import vgs_pkg::*;
    localparam int MS = 10;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic ce = 1'b1;
    logic alarm_in = 1'b0;
    logic variant_grip_check = 1'b0;
    logic signed [P_W-1:0] vac_pressure = 12'sh000;
    logic signed [P_W-1:0] grip_success_level = -12'sh12c;
    logic        [P_W-1:0] drop_hysteresis = 12'h032;
    wire logic cmd_in0, cmd_in1, status_out0, status_out1;
    wire logic valve_open, vacuum_on;
    int fails = 0;
    int check_count = 0;
    int cyc = 0;
    int n;

    vgs_sequencer #(.TICK_PERIOD(MS)) uut (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .ce(ce),
        .cmd_in0(cmd_in0), .cmd_in1(cmd_in1),
        .vac_pressure(vac_pressure),
        .grip_success_level(grip_success_level),
        .drop_hysteresis(drop_hysteresis), .alarm_in(alarm_in),
        .variant_grip_check(variant_grip_check),
        .status_out0(status_out0), .status_out1(status_out1),
        .valve_open(valve_open), .vacuum_on(vacuum_on));

    vgs_ctrl_model #(.MS(MS)) ctrl (
        .clk_sys(clk_sys), .valve_open(valve_open),
        .cmd_in0(cmd_in0), .cmd_in1(cmd_in1));

    always #25 clk_sys = ~clk_sys;

    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 80000) begin
            fails++;
            results();
        end
    end

    task automatic results();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk_bit(input string nm, input logic e, input logic g);
        check_count++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %s expected %b seen %b", nm, e, g);
        end
    endtask

    task automatic chk_rng(input string nm, input int lo, hi, g);
        check_count++;
        if (g < lo || g > hi) begin
            fails++;
            $display("[ERR] %s expected %0d..%0d seen %0d", nm, lo, hi, g);
        end
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge clk_sys);
        #2;
    endtask

    // Controller samples as soon as the status matches, and no later than ms milliseconds
    task automatic wait_st(input logic e0, e1, input int ms);
        int k;
        k = 0;
        while ({status_out0, status_out1} !== {e0, e1} && k < ms * MS) begin
            tick(1);
            k++;
        end
        chk_bit("status_out0", e0, status_out0);
        chk_bit("status_out1", e1, status_out1);
    endtask

    task automatic drive(input logic signed [P_W-1:0] p, input logic a);
        @(posedge clk_sys);
        #1;
        vac_pressure = p;
        alarm_in = a;
    endtask

    task automatic do_reset(input logic strap);
        @(posedge clk_sys);
        #1;
        sys_rst = 1'b1;
        variant_grip_check = strap;
        repeat (10) @(posedge clk_sys);
        #1;
        sys_rst = 1'b0;
        tick(1);
        chk_bit("status_out1", 1'b0, status_out1);
        chk_bit("valve_open", 1'b0, valve_open);
    endtask

    task automatic scen_grip_drop();
        drive(12'sh000, 1'b0);
        ctrl.send(2'b01);
        drive(-12'sh1f4, 1'b0);
        tick(100 * MS);
        wait_st(1'b1, 1'b0, 0);
        chk_bit("vacuum_on", 1'b1, vacuum_on);
        drive(-12'sh1f4, 1'b1);
        wait_st(1'b1, 1'b1, 2);
        drive(-12'sh1f4, 1'b0);
        wait_st(1'b1, 1'b0, 2);
        drive(-12'sh0c8, 1'b0);
        wait_st(1'b0, 1'b1, 2);
    endtask

    task automatic scen_release_regrip();
        // Already at release level: success follows one cycle after accept
        drive(12'sh000, 1'b0);
        ctrl.send(2'b10);
        wait_st(1'b0, 1'b0, 99);
        tick(1);
        chk_bit("valve_open", 1'b1, valve_open);
        chk_bit("vacuum_on", 1'b0, vacuum_on);
        drive(12'sh000, 1'b0);
        wait_st(1'b1, 1'b0, 2);
        ctrl.send(2'b01);
        n = 0;
        while (valve_open === 1'b1 && n < 99 * MS) begin
            tick(1);
            n++;
        end
        chk_rng("valve_close_cyc", 0, 22 * MS, n);
        drive(-12'sh1f4, 1'b0);
        wait_st(1'b1, 1'b0, 99);
    endtask

    task automatic scen_release_fail();
        ctrl.send(2'b10);
        n = 0;
        while (valve_open !== 1'b1 && n < 30 * MS) begin
            tick(1);
            n++;
        end
        n = 0;
        while (valve_open === 1'b1 && n < 2100 * MS) begin
            tick(1);
            n++;
        end
        chk_rng("valve_open_cyc", 2000 * MS, 2001 * MS + 2, n);
        wait_st(1'b0, 1'b1, 2);
    endtask

    task automatic scen_grip_fail();
        drive(12'sh000, 1'b0);
        ctrl.send(2'b01);
        wait_st(1'b0, 1'b0, 99);
        n = 0;
        while (status_out1 !== 1'b1 && n < 2100 * MS) begin
            tick(1);
            n++;
        end
        chk_rng("grip_fail_cyc", 1979 * MS, 2001 * MS + 3, n);
        chk_bit("status_out0", 1'b0, status_out0);
        ctrl.send(2'b11);
        wait_st(1'b0, 1'b0, 99);
    endtask

    task automatic scen_variant_b();
        @(posedge clk_sys);
        #1;
        grip_success_level = -12'sh0c8;
        drop_hysteresis = 12'h064;
        do_reset(1'b1);
        drive(12'sh000, 1'b0);
        ctrl.send(2'b01);
        drive(-12'sh1f4, 1'b0);
        wait_st(1'b1, 1'b0, 99);
        // Inside the new hysteresis band, past the old drop level
        drive(-12'sh096, 1'b0);
        tick(5 * MS);
        wait_st(1'b1, 1'b0, 0);
        // Clock enable low: no drop may be judged
        @(posedge clk_sys);
        #1;
        ce = 1'b0;
        drive(12'sh000, 1'b0);
        tick(5 * MS);
        wait_st(1'b1, 1'b0, 0);
        drive(-12'sh1f4, 1'b0);
        ce = 1'b1;
        drive(-12'sh1f4, 1'b1);
        wait_st(1'b1, 1'b1, 2);
        drive(12'sh000, 1'b1);
        tick(5 * MS);
        chk_bit("status_out0", 1'b1, status_out0);
        drive(12'sh000, 1'b0);
        wait_st(1'b0, 1'b1, 2);
    endtask

    initial begin
        do_reset(1'b0);
        scen_grip_drop();
        scen_release_regrip();
        scen_release_fail();
        scen_grip_fail();
        scen_variant_b();
        results();
    end
endmodule

// File: dv/vgs_ctrl_model.sv
/*
 Robot controller model: drives the two command lines of the sequencer.
 Assumes the bench calls send() and valve_open comes from the sequencer.
*/
`timescale 1ns/100ps
module vgs_ctrl_model #(
    parameter int MS = 10
) (
    input  wire logic clk_sys,
    input  wire logic valve_open,
    output logic      cmd_in0,
    output logic      cmd_in1
);
    int cyc     = 0;
    int t_cmd   = -1000000;
    int t_close = -1000000;

    initial begin
        cmd_in0 = 1'b0;
        cmd_in1 = 1'b0;
    end

    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
    end

    // The unknown-to-low step at start-up is not a valve close
    always @(negedge valve_open) begin
        if (cyc > 2) begin
            t_close = cyc;
        end
    end

    // Pattern is {line 1, line 0}
    task automatic send(input logic [1:0] pat);
        while (cyc - t_cmd < 200 * MS) @(posedge clk_sys);
        if (pat == 2'b10) begin
            // Let the valve coil cool before reopening it
            while (valve_open || cyc - t_close < 2000 * MS)
                @(posedge clk_sys);
        end
        @(posedge clk_sys);
        #1;
        {cmd_in1, cmd_in0} = pat;
        t_cmd = cyc;
    endtask
endmodule

// File: rtl/vgs_pkg.sv
/*
 Package for the vacuum gripper I/O sequencer: time bases, counts,
 pressure scaling and the sequencer states.
 Assumes a 20 MHz system clock and pressure in signed 0.1 kPa steps.
*/
package vgs_pkg;
    localparam int          CLK_HZ          = 20_000_000;
    localparam int          MS_PER_S        = 1000;
    localparam int          TICK_CYCLES     = CLK_HZ / MS_PER_S;
    localparam int          MS_W            = 12;
    localparam int          P_W             = 12;
    // Times in milliseconds
    localparam logic [11:0] CMD_STABLE_MS   = 12'h014;
    localparam logic [11:0] GRIP_ERR_MS     = 12'h7d0;
    localparam logic [11:0] VALVE_OPEN_MS   = 12'h7d0;
    localparam logic [11:0] STATUS_LAG_MS   = 12'h063;
    // Release success threshold, -1.0 kPa in 0.1 kPa units
    localparam logic signed [11:0] REL_OK_LEVEL = -12'sh00a;
    localparam logic [1:0]  STATUS_RST      = 2'h0;

    typedef enum logic [1:0] {
        VGS_CMD_IDLE,
        VGS_CMD_GRIP,
        VGS_CMD_RELEASE
    } vgs_cmd_type;

    typedef enum logic [2:0] {
        VGS_ST_IDLE,
        VGS_ST_GRIP_WAIT,
        VGS_ST_GRIPPING,
        VGS_ST_GRIP_FAIL,
        VGS_ST_DROPPED,
        VGS_ST_RELEASING,
        VGS_ST_RELEASED,
        VGS_ST_REL_FAIL
    } vgs_state_type;
endpackage

// File: rtl/vgs_sequencer.sv
/*
 Vacuum gripper command/status sequencer: decodes the two command lines,
 runs grip, drop and release judgement, times the release valve and
 drives the two status lines in either output variant.
 Assumes command lines and pressure are synchronous to clk_sys, the
 variant strap is static, and the controller holds commands >= 200 ms.
*/
`timescale 1ns/100ps
module vgs_sequencer #(
    parameter int TICK_PERIOD = vgs_pkg::TICK_CYCLES
) (
    input  wire logic                        clk_sys,
    input  wire logic                        sys_rst,
    input  wire logic                        ce,
    input  wire logic                        cmd_in0,
    input  wire logic                        cmd_in1,
    input  wire logic signed [vgs_pkg::P_W-1:0] vac_pressure,
    input  wire logic signed [vgs_pkg::P_W-1:0] grip_success_level,
    input  wire logic        [vgs_pkg::P_W-1:0] drop_hysteresis,
    input  wire logic                        alarm_in,
    input  wire logic                        variant_grip_check,
    output logic                             status_out0,
    output logic                             status_out1,
    output logic                             valve_open,
    output logic                             vacuum_on
);
    import vgs_pkg::*;

    logic                   tick;
    vgs_cmd_type            cmd_raw;
    vgs_cmd_type            cand_r;
    vgs_cmd_type            cmd_r;
    logic [MS_W-1:0]        stable_ms_r;
    logic                   new_cmd;
    logic [MS_W-1:0]        phase_ms_r;
    logic [MS_W-1:0]        valve_ms_r;
    vgs_state_type          state_r;
    vgs_state_type          state_nxt;
    logic                   variant_r;
    logic signed [P_W:0]    drop_level;
    logic                   grip_ok;
    logic                   dropped;
    logic                   rel_ok;
    logic                   grip_seen_r;
    logic                   out0_nxt;
    logic                   out1_nxt;

    vgs_tick_gen #(
        .PERIOD (TICK_PERIOD)
    ) u_tick (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .ce      (ce),
        .tick    (tick)
    );

    // Command decode
    always_comb begin
        if (cmd_in0 && !cmd_in1) begin
            cmd_raw = VGS_CMD_GRIP;
        end else if (!cmd_in0 && cmd_in1) begin
            cmd_raw = VGS_CMD_RELEASE;
        end else begin
            cmd_raw = VGS_CMD_IDLE;
        end
    end

    // Pattern must stand for CMD_STABLE_MS before it counts
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            cand_r      <= VGS_CMD_IDLE;
            stable_ms_r <= '0;
        end else if (ce) begin
            if (cmd_raw != cand_r) begin
                cand_r      <= cmd_raw;
                stable_ms_r <= '0;
            end else if (tick && stable_ms_r != CMD_STABLE_MS) begin
                stable_ms_r <= stable_ms_r + 12'h001;
            end
        end
    end

    assign new_cmd = (stable_ms_r == CMD_STABLE_MS) && (cand_r == cmd_raw)
                     && (cand_r != cmd_r);

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            cmd_r <= VGS_CMD_IDLE;
        end else if (ce && new_cmd) begin
            cmd_r <= cand_r;
        end
    end

    // Strap caught while reset is held
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            variant_r <= variant_grip_check;
        end
    end

    // Time since the current command
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            phase_ms_r <= '0;
        end else if (ce) begin
            if (new_cmd) begin
                phase_ms_r <= '0;
            end else if (tick && phase_ms_r != GRIP_ERR_MS) begin
                phase_ms_r <= phase_ms_r + 12'h001;
            end
        end
    end

    // Both sides signed so a drop level on either side of zero compares right
    assign drop_level = $signed({grip_success_level[P_W-1],
                                 grip_success_level})
                        + $signed({1'b0, drop_hysteresis});
    assign grip_ok = vac_pressure <= grip_success_level;
    assign dropped = $signed({vac_pressure[P_W-1], vac_pressure})
                     > drop_level;
    assign rel_ok  = vac_pressure >= REL_OK_LEVEL;

    always_comb begin
        state_nxt = state_r;
        if (new_cmd) begin
            case (cand_r)
                VGS_CMD_GRIP:    state_nxt = VGS_ST_GRIP_WAIT;
                VGS_CMD_RELEASE: state_nxt = VGS_ST_RELEASING;
                default:         state_nxt = VGS_ST_IDLE;
            endcase
        end else begin
            case (state_r)
                VGS_ST_GRIP_WAIT: begin
                    if (grip_ok) begin
                        state_nxt = VGS_ST_GRIPPING;
                    end else if (phase_ms_r == GRIP_ERR_MS) begin
                        state_nxt = VGS_ST_GRIP_FAIL;
                    end
                end
                VGS_ST_GRIPPING: begin
                    if (dropped) begin
                        state_nxt = VGS_ST_DROPPED;
                    end
                end
                VGS_ST_RELEASING: begin
                    if (rel_ok) begin
                        state_nxt = VGS_ST_RELEASED;
                    end else if (valve_ms_r == VALVE_OPEN_MS) begin
                        state_nxt = VGS_ST_REL_FAIL;
                    end
                end
                default: state_nxt = state_r;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state_r <= VGS_ST_IDLE;
        end else if (ce) begin
            state_r <= state_nxt;
        end
    end

    // Release valve: fixed open time, cut short by a grip command
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            valve_open <= 1'b0;
            valve_ms_r <= '0;
        end else if (ce) begin
            if (new_cmd && cand_r == VGS_CMD_RELEASE) begin
                valve_open <= 1'b1;
                valve_ms_r <= '0;
            end else if (new_cmd && cand_r == VGS_CMD_GRIP) begin
                valve_open <= 1'b0;
            // Close on the tick after the full count: open time never short
            end else if (valve_open && tick && valve_ms_r == VALVE_OPEN_MS) begin
                valve_open <= 1'b0;
            end else if (valve_open && tick) begin
                valve_ms_r <= valve_ms_r + 12'h001;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            vacuum_on <= 1'b0;
        end else if (ce && new_cmd) begin
            vacuum_on <= (cand_r == VGS_CMD_GRIP);
        end
    end

    // Gripping level for the grip-check variant
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            grip_seen_r <= 1'b0;
        end else if (ce) begin
            grip_seen_r <= (state_nxt == VGS_ST_GRIPPING);
        end
    end

    always_comb begin
        out0_nxt = 1'b0;
        out1_nxt = 1'b0;
        if (variant_r) begin
            // Line 0 frozen while the alarm stands
            out0_nxt = alarm_in ? status_out0 : grip_seen_r;
            out1_nxt = alarm_in || state_r == VGS_ST_GRIP_FAIL
                       || state_r == VGS_ST_DROPPED
                       || state_r == VGS_ST_REL_FAIL;
        end else if (alarm_in) begin
            out0_nxt = 1'b1;
            out1_nxt = 1'b1;
        end else begin
            case (state_r)
                VGS_ST_GRIPPING,
                VGS_ST_RELEASED: out0_nxt = 1'b1;
                VGS_ST_GRIP_FAIL,
                VGS_ST_DROPPED,
                VGS_ST_REL_FAIL: out1_nxt = 1'b1;
                default:         out0_nxt = 1'b0;
            endcase
        end
    end

    // Status follows state one cycle later, well inside the lag limit
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            {status_out0, status_out1} <= STATUS_RST;
        end else if (ce) begin
            status_out0 <= out0_nxt;
            status_out1 <= out1_nxt;
        end
    end

    a_valve_max_open: assert property (@(posedge clk_sys) disable iff (sys_rst)
        valve_open |-> valve_ms_r <= VALVE_OPEN_MS)
        else $error("release valve open past its fixed time");

    a_valve_opens: assert property (@(posedge clk_sys) disable iff (sys_rst)
        ce && new_cmd && cand_r == VGS_CMD_RELEASE |=> valve_open)
        else $error("release command did not open valve");

    a_grip_closes: assert property (@(posedge clk_sys) disable iff (sys_rst)
        ce && new_cmd && cand_r == VGS_CMD_GRIP |=> !valve_open)
        else $error("grip command left valve open");

    a_grip_timeout: assert property (@(posedge clk_sys) disable iff (sys_rst)
        ce && !new_cmd && state_r == VGS_ST_GRIP_WAIT && !grip_ok
        && phase_ms_r == GRIP_ERR_MS |=> state_r == VGS_ST_GRIP_FAIL)
        else $error("grip timeout not judged as failure");

    a_fail_clear: assert property (@(posedge clk_sys) disable iff (sys_rst)
        ce && new_cmd && !alarm_in ##1 ce && !alarm_in
        |=> !status_out1)
        else $error("status line 1 not cleared by new command");

    a_status_lag: assert property (@(posedge clk_sys) disable iff (sys_rst)
        ce && new_cmd && cand_r == VGS_CMD_RELEASE && !variant_r
        && !alarm_in ##1 ce && rel_ok && !alarm_in
        ##1 ce && !alarm_in |=> status_out0 && !status_out1)
        else $error("release success not shown on line 0");

    a_cmd_decode: assert property (@(posedge clk_sys) disable iff (sys_rst)
        ce && new_cmd && cmd_in0 && cmd_in1 |=> cmd_r == VGS_CMD_IDLE)
        else $error("both lines high not decoded as idle");

    a_alarm_both: assert property (@(posedge clk_sys) disable iff (sys_rst)
        ce && !variant_r && alarm_in |=> status_out0 && status_out1)
        else $error("alarm not shown as both lines");

    a_alarm_hold0: assert property (@(posedge clk_sys) disable iff (sys_rst)
        ce && variant_r && alarm_in |=> $stable(status_out0))
        else $error("grip check line moved during alarm");

    a_variant_static: assert property (@(posedge clk_sys) disable iff (sys_rst)
        ##1 $stable(variant_r))
        else $error("output variant changed in operation");
endmodule

// File: rtl/vgs_tick_gen.sv
/*
 Millisecond tick generator: one-cycle pulse every PERIOD enabled cycles.
 Assumes a synchronous active-high reset and a clock enable.
*/
`timescale 1ns/100ps
module vgs_tick_gen #(
    parameter int PERIOD = 20000
) (
    input  wire logic clk_sys,
    input  wire logic sys_rst,
    input  wire logic ce,
    output logic      tick
);
    logic [15:0] cnt_r;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            cnt_r <= 16'h0000;
            tick  <= 1'b0;
        end else if (ce) begin
            if (cnt_r == 16'(PERIOD - 1)) begin
                cnt_r <= 16'h0000;
                tick  <= 1'b1;
            end else begin
                cnt_r <= cnt_r + 16'h0001;
                tick  <= 1'b0;
            end
        end
    end
endmodule
